//--- design/urx_crc_rx.v
// Notes on behaviour
// - Bad CRC, non-isochronous: drop data, no ACK
// - Bad CRC, isochronous: flag software, keep data
// - Non-isochronous CRC failure raises no software flag
// - Cross PHY controls safely; good CRC never fails
`timescale 1ns/1ns
`default_nettype none

`include "urx_defines.vh"

module urx_crc_rx (
  input wire core_clk,
  input wire reset_n,
  input wire phy_rx_active,
  input wire phy_rx_byte_tgl,
  input wire [`URX_DATA_W-1:0] phy_rx_data,
  input wire ep_is_iso,
  output reg fifo_wr_en_r,
  output reg [`URX_DATA_W-1:0] fifo_wr_data_r,
  output reg fifo_commit_r,
  output reg fifo_discard_r,
  output reg send_ack_r,
  output reg iso_crc_err_r,
  output reg [`URX_CNT_W-1:0] rx_count_r,
  output reg rx_done_r
);

  // CRC16 over one byte, LSB first
  function [15:0] crc16_byte;
    input [15:0] crc_in;
    input [7:0] din;
    integer i;
    reg [15:0] c;
    begin
      c = crc_in;
      for (i = 0; i < 8; i = i + 1) begin
        if (c[0] ^ din[i]) begin
          c = (c >> 1) ^ `URX_CRC_POLY;
        end else begin
          c = c >> 1;
        end
      end
      crc16_byte = c;
    end
  endfunction

  wire [`URX_DATA_W+1:0] sync_q; // Synchronised PHY controls and data
  wire s_active; // Packet in progress
  wire s_tgl; // Flips once per byte
  wire [`URX_DATA_W-1:0] s_data; // Byte lane

  reg tgl_d_r; // Previous toggle level
  reg act_d_r; // Previous active level
  reg take_r; // Byte lane is settled, take it
  reg [`URX_END_DLY-1:0] end_sh_r; // End of packet delayed
  reg first_r; // Next byte is the PID
  reg [15:0] crc_r; // Running CRC
  reg [1:0] held_r; // Bytes in holding pair
  reg [`URX_DATA_W-1:0] hold0_r; // Oldest held byte
  reg [`URX_DATA_W-1:0] hold1_r; // Newest held byte
  reg [`URX_CNT_W-1:0] cnt_r; // Bytes passed to the FIFO

  wire byte_evt; // Toggle edge seen
  wire start_evt; // Packet start
  wire end_evt; // Packet end
  wire pkt_bad; // CRC wrong or packet too short

  // Every PHY input passes two flops before use
  urx_sync #(
    .W(`URX_DATA_W + 2)
  ) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in({phy_rx_active, phy_rx_byte_tgl, phy_rx_data}),
    .sync_out(sync_q)
  );

  assign s_active = sync_q[`URX_DATA_W+1];
  assign s_tgl = sync_q[`URX_DATA_W];
  assign s_data = sync_q[`URX_DATA_W-1:0];
  assign byte_evt = s_tgl ^ tgl_d_r;
  assign start_evt = s_active & ~act_d_r;
  assign end_evt = act_d_r & ~s_active;
  assign pkt_bad = (crc_r != `URX_CRC_GOOD) || (held_r != `URX_HOLD_N);

  // Event detection; the byte is taken one cycle after its toggle
  // so lane bits skewed against the toggle have settled
  always @(posedge core_clk) begin
    if (!reset_n) begin
      tgl_d_r <= 1'b0;
      act_d_r <= 1'b0;
      take_r <= 1'b0;
      end_sh_r <= {`URX_END_DLY{1'b0}};
    end else begin
      tgl_d_r <= s_tgl;
      act_d_r <= s_active;
      take_r <= byte_evt;
      // Verdict waits until the last byte is surely taken
      end_sh_r <= {end_sh_r[`URX_END_DLY-2:0], end_evt};
    end
  end

  // Byte intake, CRC, two-byte hold-back and FIFO writes
  always @(posedge core_clk) begin
    if (!reset_n) begin
      first_r <= 1'b1;
      crc_r <= `URX_CRC_INIT;
      held_r <= 2'h0;
      hold0_r <= 8'h00;
      hold1_r <= 8'h00;
      cnt_r <= {`URX_CNT_W{1'b0}};
      fifo_wr_en_r <= 1'b0;
      fifo_wr_data_r <= 8'h00;
    end else begin
      fifo_wr_en_r <= 1'b0;
      if (start_evt) begin
        // New packet: reset PID flag, CRC, hold count and byte count; held bytes keep old values
        first_r <= 1'b1;
        crc_r <= `URX_CRC_INIT;
        held_r <= 2'h0;
        cnt_r <= {`URX_CNT_W{1'b0}};
      end else if (take_r) begin
        if (first_r) begin
          // PID byte, not payload
          first_r <= 1'b0;
        end else begin
          crc_r <= crc16_byte(crc_r, s_data);
          if (held_r == `URX_HOLD_N) begin
            // Oldest held byte is payload for sure
            fifo_wr_en_r <= 1'b1;
            fifo_wr_data_r <= hold0_r;
            cnt_r <= cnt_r + 1'b1;
            hold0_r <= hold1_r;
            hold1_r <= s_data;
          end else if (held_r == 2'h1) begin
            // Second payload byte
            hold1_r <= s_data;
            held_r <= `URX_HOLD_N;
          end else begin
            // First payload byte
            hold0_r <= s_data;
            held_r <= 2'h1;
          end
        end
      end
    end
  end

  // End-of-packet verdict
  always @(posedge core_clk) begin
    if (!reset_n) begin
      fifo_commit_r <= 1'b0;
      fifo_discard_r <= 1'b0;
      send_ack_r <= 1'b0;
      iso_crc_err_r <= 1'b0;
      rx_count_r <= {`URX_CNT_W{1'b0}};
      rx_done_r <= 1'b0;
    end else begin
      fifo_commit_r <= 1'b0;
      fifo_discard_r <= 1'b0;
      send_ack_r <= 1'b0;
      iso_crc_err_r <= 1'b0;
      rx_done_r <= 1'b0;
      if (end_sh_r[`URX_END_DLY-1]) begin
        if (ep_is_iso) begin
          // Isochronous: keep data whatever the CRC, no handshake
          fifo_commit_r <= 1'b1;
          iso_crc_err_r <= pkt_bad;
          rx_count_r <= cnt_r;
          rx_done_r <= 1'b1;
        end else if (pkt_bad) begin
          // Drop data, stay silent so the host resends; no flag
          fifo_discard_r <= 1'b1;
        end else begin
          // Good packet: keep data and acknowledge
          fifo_commit_r <= 1'b1;
          send_ack_r <= 1'b1;
          rx_count_r <= cnt_r;
          rx_done_r <= 1'b1;
        end
      end
    end
  end

endmodule // urx_crc_rx

`default_nettype wire

//--- design/urx_defines.vh
`ifndef URX_DEFINES_VH
`define URX_DEFINES_VH

// Width of the PHY byte lane
`define URX_DATA_W 8
// Width of the received byte counter, enough for 1024-byte packets
`define URX_CNT_W 11
// CRC16 preset value, reflected register form
`define URX_CRC_INIT 16'hFFFF
// CRC16 polynomial, reflected form
`define URX_CRC_POLY 16'hA001
// Register value left after a good packet runs through, CRC bytes included
`define URX_CRC_GOOD 16'hB001
// Bytes held back so that the two CRC bytes never reach the FIFO
`define URX_HOLD_N 2'h2
// Core cycles from end of packet seen to the verdict
`define URX_END_DLY 2

`endif

//--- design/urx_sync.v
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser bank for PHY-side levels
module urx_sync #(
  parameter W = 10
) (
  input wire core_clk,
  input wire reset_n,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_r; // First stage, read only by second stage
  reg [W-1:0] sync_r; // Second stage, safe to use

  // Two flops in series per bit
  always @(posedge core_clk) begin
    if (!reset_n) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule // urx_sync

`default_nettype wire

//--- bench/urx_crc_rx_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "urx_defines.vh"
// Verdict-pulse relations of the receive CRC block
module urx_crc_rx_sva (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic fifo_wr_en_r,
  input wire logic fifo_commit_r,
  input wire logic fifo_discard_r,
  input wire logic send_ack_r,
  input wire logic iso_crc_err_r,
  input wire logic [`URX_CNT_W-1:0] rx_count_r,
  input wire logic rx_done_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_drop_no_ack: assert property (fifo_discard_r |-> !send_ack_r && !fifo_commit_r)
    else $error("discard came with ack or commit");
  a_ack_keeps: assert property (send_ack_r |-> fifo_commit_r && !iso_crc_err_r)
    else $error("ack without commit");
  a_quiet_drop: assert property (fifo_discard_r |-> !iso_crc_err_r && !rx_done_r)
    else $error("dropped packet signalled software");
  a_iso_keep: assert property (iso_crc_err_r |-> fifo_commit_r && rx_done_r)
    else $error("iso error without keep");
  a_count_hold: assert property ($changed(rx_count_r) |-> rx_done_r)
    else $error("count moved without done");
  a_end_clean: assert property (rx_done_r |-> !fifo_wr_en_r ##1 !fifo_wr_en_r)
    else $error("write overlaps verdict");
endmodule // urx_crc_rx_sva
bind urx_crc_rx urx_crc_rx_sva chk_i (.core_clk(core_clk), .reset_n(reset_n),
  .fifo_wr_en_r(fifo_wr_en_r), .fifo_commit_r(fifo_commit_r),
  .fifo_discard_r(fifo_discard_r), .send_ack_r(send_ack_r),
  .iso_crc_err_r(iso_crc_err_r), .rx_count_r(rx_count_r),
  .rx_done_r(rx_done_r));
`default_nettype wire

//--- bench/urx_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host side seen through the PHY byte lane
module urx_host_model (
  input wire logic core_clk,
  output logic rx_active,
  output logic rx_tgl,
  output logic [7:0] rx_data
);
  initial begin
    rx_active = 1'b0;
    rx_tgl = 1'b0;
    rx_data = 8'h00;
  end
  // PID, payload, CRC16 low byte first; bad spoils the CRC
  task automatic send(input logic [7:0] pl[$], input bit bad);
    logic [15:0] c;
    logic [7:0] b[$];
    c = 16'hFFFF;
    foreach (pl[i]) for (int k = 0; k < 8; k++)
      c = (c >> 1) ^ ((c[0] ^ pl[i][k]) ? 16'hA001 : 16'h0000);
    c = ~c ^ {15'h0000, bad};
    b = {8'hC3};
    b = {b, pl, c[7:0], c[15:8]};
    @(posedge core_clk);
    #1 rx_active = 1'b1;
    // Five cycles per byte keeps above the minimum spacing
    foreach (b[i]) begin
      repeat (5) @(posedge core_clk);
      #1 rx_data = b[i];
      rx_tgl = ~rx_tgl;
    end
    repeat (4) @(posedge core_clk);
    // Released lane shows no stale byte
    #1 rx_active = 1'b0;
    rx_data = ~rx_data;
    repeat (10) @(posedge core_clk);
  endtask
endmodule // urx_host_model
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic core_clk = 1'b0, reset_n = 1'b0, ep_is_iso = 1'b0;
  logic act, tgl, wr, com, dis, ack, err, done;
  logic [7:0] d, wd;
  logic [10:0] cnt;
  logic [4:0] ev;
  logic [7:0] got[$];
  int checked = 0, miscompares = 0;
  always #4 core_clk = ~core_clk;
  urx_host_model host (.core_clk(core_clk), .rx_active(act), .rx_tgl(tgl),
    .rx_data(d));
  urx_crc_rx dut (.core_clk(core_clk), .reset_n(reset_n), .phy_rx_active(act),
    .phy_rx_byte_tgl(tgl), .phy_rx_data(d), .ep_is_iso(ep_is_iso),
    .fifo_wr_en_r(wr), .fifo_wr_data_r(wd), .fifo_commit_r(com),
    .fifo_discard_r(dis), .send_ack_r(ack), .iso_crc_err_r(err),
    .rx_count_r(cnt), .rx_done_r(done));
  // Collect written bytes and verdict pulses
  always @(posedge core_clk) begin
    if (wr === 1'b1) got.push_back(wd);
    ev <= ev | {com, dis, ack, err, done};
  end
  task automatic chk(input string nm, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One packet, then verdict, count and kept bytes
  task automatic pkt(input logic [7:0] pl[$], input bit bad, iso,
      input logic [4:0] xe);
    #1 ep_is_iso = iso;
    ev = 5'h00;
    got = {};
    host.send(pl, bad);
    chk("verdict", {11'h000, xe}, {11'h000, ev});
    if (xe[4]) begin
      chk("count", pl.size(), {5'h00, cnt});
      chk("bytes", pl.size(), got.size());
      foreach (pl[i]) chk("byte", pl[i], got[i]);
    end
  endtask
  task t_good_bulk;
    pkt({8'h5A, 8'h00, 8'hFF}, 0, 0, 5'h15);
    $display("t_good_bulk done");
  endtask
  task t_bad_bulk;
    pkt({8'h12, 8'h34}, 1, 0, 5'h08);
    pkt({8'h12, 8'h34}, 0, 0, 5'h15);
    $display("t_bad_bulk done");
  endtask
  // Three bad packets are dropped, then the host resends a good one that gets through
  task t_retry;
    repeat (3) pkt({8'h77, 8'h01}, 1, 0, 5'h08);
    pkt({8'h77, 8'h01}, 0, 0, 5'h15);
    $display("t_retry done");
  endtask
  task t_iso;
    pkt({8'hA5, 8'h3C}, 1, 1, 5'h13);
    pkt({8'h81}, 0, 1, 5'h11);
    $display("t_iso done");
  endtask
  task results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge core_clk);
    t_good_bulk();
    t_bad_bulk();
    t_retry();
    t_iso();
    results();
  end
endmodule // testbench
`default_nettype wire
